// *** rtl/tap_bridge_pkg.sv ***
package tap_bridge_pkg;
    localparam int IR_W = 8;
    localparam logic [7:0] USER_IR_LO = 8'h10;
    localparam logic [7:0] USER_IR_HI = 8'h7F;
    localparam logic [7:0] IR_CAPTURE = 8'h01;
    localparam logic [7:0] IR_RESET = 8'hFF;
    localparam int CFG_W = 81;
    localparam int FIFO_W = 1;
    localparam int FIFO_DEPTH = 32;
    localparam logic [2:0] TMS_RESET_COUNT = 3'h5;
    localparam logic [3:0] REG_CTRL = 4'h0;
    localparam logic [3:0] REG_STATUS = 4'h4;
    localparam logic [3:0] REG_IR = 4'h8;
    localparam logic [3:0] REG_LOAD = 4'hC;
    localparam int CTRL_DYN_BIT = 0;
    localparam int CTRL_HOLD_BIT = 1;
    localparam logic [1:0] CTRL_RESET = 2'h0;
    localparam logic [31:0] RDATA_NONE = 32'h0000_0000;

    typedef enum logic [3:0] {
        TLR, RTI, SEL_DR, CAP_DR, SH_DR, EX1_DR, PA_DR, EX2_DR, UP_DR,
        SEL_IR, CAP_IR, SH_IR, EX1_IR, PA_IR, EX2_IR, UP_IR
    } tap_state_t;

    typedef struct packed {
        logic trst_n;
        logic tck;
        logic tms;
        logic tdi;
        logic user_out;
    } pins_t;

    localparam pins_t PINS_RESET = '{1'b1, 1'b0, 1'b1, 1'b0, 1'b0};

    typedef struct packed {
        logic reset_enable;
        logic dynamic_select_c;
        logic dynamic_select_b;
        logic dynamic_select_a;
        logic [2:0] oscillator_range_select;
        logic static_select_c;
        logic static_select_b;
        logic static_select_a;
        logic [4:0] delay_c;
        logic [4:0] delay_b;
        logic [4:0] global_c_delay;
        logic [4:0] global_b_delay;
        logic [4:0] global_a_delay;
        logic extra_delay_select;
        logic [4:0] feedback_delay;
        logic [1:0] feedback_source_select;
        logic [2:0] output_c_mux_select;
        logic [2:0] output_b_mux_select;
        logic [2:0] output_a_mux_select;
        logic [4:0] output_c_divider;
        logic [4:0] output_b_divider;
        logic [4:0] output_a_divider;
        logic [6:0] feedback_divider;
        logic [6:0] input_divider;
    } cc_cfg_t;

    localparam cc_cfg_t STATIC_CFG = '0;
endpackage

// *** rtl/user_tap_bridge_tile.sv ***
// Function
// R1: update_ir loads the instruction register onto the 8-bit user instruction bus
// R2: instructions 16 to 127 are free for user commands
// R3: core tap reset is low while in test-logic-reset
// R4: core tap reset is low from power-up until the host leaves test-logic-reset
// R5: user serial input follows tdi, user shift clock follows tck
// R6: user serial output drives tdo for user-range instructions
// R7: shift, capture and update flags high only in their dr states
// R8: sixteen-state tap machine moves only on rising tck, steered by tms
// R9: power-on reset or trst forces test-logic-reset at once
// R10: five tms-high tck cycles reach test-logic-reset from anywhere
// R11: ir states work the instruction register, dr states the data register
// R12: host walks a full ir path to load a new instruction
// R13: tdi carries dr bits in shift_dr, ir bits in shift_ir
// R14: core treats shift flag as valid data, update flag as end of stream
// R15: conditioner config from static settings or the 81-bit shift register
// R16: 81 config bits hold selects, range, delays, muxes and dividers
// R17: a new conditioner config loads while the device keeps running
// R18: core logic supplies the config bits and controls shift and load
// R19: state flags decoded from the tap state register
`timescale 1ns/1ps

module cfg_bit_fifo #(
    parameter int W = 1,
    parameter int DEPTH = 32
) (
    input wire logic clk_sys_in,
    input wire logic rst_in,
    input wire logic [W-1:0] in_data_in,
    input wire logic in_valid_in,
    output logic in_ready_out,
    output logic [W-1:0] out_data_out,
    output logic out_valid_out,
    input wire logic out_ready_in
);
    localparam int AW = $clog2(DEPTH);
    localparam logic [AW:0] FULL = (AW+1)'(DEPTH);
    logic [W-1:0] mem [DEPTH];
    logic [AW-1:0] wr_ptr;
    logic [AW-1:0] rd_ptr;
    logic [AW:0] count;
    logic [AW:0] next_count;
    wire push = in_valid_in && in_ready_out;
    wire pop = out_valid_out && out_ready_in;

    assign out_valid_out = count != '0;
    assign out_data_out = mem[rd_ptr];
    assign next_count = count + (AW+1)'(push) - (AW+1)'(pop);

    always_ff @(posedge clk_sys_in)
    begin
        if (push)
        begin
            mem[wr_ptr] <= in_data_in;
        end
    end

    always_ff @(posedge clk_sys_in)
    begin
        if (rst_in)
        begin
            wr_ptr <= '0;
            rd_ptr <= '0;
            count <= '0;
            in_ready_out <= 1'b0;
        end
        else
        begin
            wr_ptr <= push ? wr_ptr + AW'(1) : wr_ptr;
            rd_ptr <= pop ? rd_ptr + AW'(1) : rd_ptr;
            count <= next_count;
            in_ready_out <= next_count != FULL;
        end
    end
endmodule

module user_tap_bridge_tile
    import tap_bridge_pkg::*;
(
    input wire logic clk_sys_in,
    input wire logic rst_in,
    input wire logic tck_in,
    input wire logic tms_in,
    input wire logic tdi_in,
    input wire logic trst_n_in,
    output logic tdo_out,
    output logic tdo_oe_out,
    output logic [IR_W-1:0] user_instruction_bus_out,
    output logic tap_reset_n_out,
    output logic user_serial_in_out,
    output logic user_shift_clock_out,
    output logic shift_dr_flag_out,
    output logic capture_dr_flag_out,
    output logic update_dr_flag_out,
    input wire logic user_serial_out_in,
    input wire logic cfg_bit_in,
    input wire logic cfg_valid_in,
    output logic cfg_ready_out,
    output cc_cfg_t clock_conditioner_out,
    input wire logic [3:0] reg_addr_in,
    input wire logic [31:0] reg_wdata_in,
    input wire logic reg_wr_in,
    input wire logic reg_rd_in,
    output logic [31:0] reg_rdata_out
);
    pins_t s1;
    pins_t s2;
    pins_t s3;
    tap_state_t state;
    tap_state_t next_state;
    logic [IR_W-1:0] ir_shift;
    logic bypass;
    logic [2:0] tms_cnt;
    logic [1:0] ctrl;
    logic [CFG_W-1:0] cfg_shift;
    cc_cfg_t cfg_active;
    logic fifo_bit;
    logic fifo_valid;
    logic [31:0] next_rdata;

    // pin synchronisers, s3 only gives the previous s2 for edge finding
    wire pins_t pins_now = '{trst_n_in, tck_in, tms_in, tdi_in, user_serial_out_in};
    wire tck_rise = s2.tck && !s3.tck;
    wire tck_fall = !s2.tck && s3.tck;
    wire force_tlr = !s2.trst_n;
    wire user_range = (user_instruction_bus_out >= USER_IR_LO) &&
        (user_instruction_bus_out <= USER_IR_HI); // R2
    wire drain = fifo_valid && !ctrl[CTRL_HOLD_BIT];
    wire wr_ctrl = reg_wr_in && (reg_addr_in == REG_CTRL);
    wire wr_load = reg_wr_in && (reg_addr_in == REG_LOAD);
    wire [31:0] status_word = {16'h0000, user_instruction_bus_out, 2'b00,
        fifo_valid, tap_reset_n_out, state};

    always_ff @(posedge clk_sys_in)
    begin
        if (rst_in)
        begin
            s1 <= PINS_RESET;
            s2 <= PINS_RESET;
            s3 <= PINS_RESET;
        end
        else
        begin
            s1 <= pins_now;
            s2 <= s1;
            s3 <= s2;
        end
    end

    // tap next-state decode
    always_comb
    begin
        next_state = state;
        case (state)
            TLR: next_state = s2.tms ? TLR : RTI;
            RTI: next_state = s2.tms ? SEL_DR : RTI;
            SEL_DR: next_state = s2.tms ? SEL_IR : CAP_DR;
            CAP_DR: next_state = s2.tms ? EX1_DR : SH_DR;
            SH_DR: next_state = s2.tms ? EX1_DR : SH_DR;
            EX1_DR: next_state = s2.tms ? UP_DR : PA_DR;
            PA_DR: next_state = s2.tms ? EX2_DR : PA_DR;
            EX2_DR: next_state = s2.tms ? UP_DR : SH_DR;
            UP_DR: next_state = s2.tms ? SEL_DR : RTI;
            SEL_IR: next_state = s2.tms ? TLR : CAP_IR;
            CAP_IR: next_state = s2.tms ? EX1_IR : SH_IR;
            SH_IR: next_state = s2.tms ? EX1_IR : SH_IR;
            EX1_IR: next_state = s2.tms ? UP_IR : PA_IR;
            PA_IR: next_state = s2.tms ? EX2_IR : PA_IR;
            EX2_IR: next_state = s2.tms ? UP_IR : SH_IR;
            UP_IR: next_state = s2.tms ? SEL_DR : RTI;
            default: next_state = TLR;
        endcase
    end

    always_ff @(posedge clk_sys_in)
    begin
        if (rst_in || force_tlr)
        begin
            state <= TLR; // R9
        end
        else if (tck_rise)
        begin
            state <= next_state; // R8 R10 R12
        end
    end

    always_ff @(posedge clk_sys_in)
    begin
        if (rst_in)
        begin
            tms_cnt <= 3'h0;
        end
        else if (tck_rise)
        begin
            tms_cnt <= !s2.tms ? 3'h0 :
                (tms_cnt == TMS_RESET_COUNT) ? tms_cnt : tms_cnt + 3'h1;
        end
    end

    // instruction and bypass paths
    always_ff @(posedge clk_sys_in)
    begin
        if (rst_in)
        begin
            ir_shift <= IR_CAPTURE;
            bypass <= 1'b0;
        end
        else if (tck_rise && !force_tlr)
        begin
            case (state)
                CAP_IR: ir_shift <= IR_CAPTURE; // R11
                SH_IR: ir_shift <= {s2.tdi, ir_shift[IR_W-1:1]}; // R11 R13
                CAP_DR: bypass <= 1'b0; // R11
                SH_DR: bypass <= s2.tdi; // R11 R13
                default: bypass <= bypass;
            endcase
        end
    end

    always_ff @(posedge clk_sys_in)
    begin
        if (rst_in || state == TLR)
        begin
            user_instruction_bus_out <= IR_RESET;
        end
        else if (tck_rise && !force_tlr && next_state == UP_IR)
        begin
            user_instruction_bus_out <= ir_shift; // R1
        end
    end

    // tdo changes on falling tck
    always_ff @(posedge clk_sys_in)
    begin
        if (rst_in)
        begin
            tdo_out <= 1'b0;
            tdo_oe_out <= 1'b0;
        end
        else if (tck_fall)
        begin
            tdo_oe_out <= (state == SH_IR) || (state == SH_DR);
            if (state == SH_IR)
            begin
                tdo_out <= ir_shift[0];
            end
            else if (state == SH_DR)
            begin
                tdo_out <= user_range ? s2.user_out : bypass; // R6
            end
        end
    end

    // core-side flags and pass-through
    always_ff @(posedge clk_sys_in)
    begin
        if (rst_in)
        begin
            tap_reset_n_out <= 1'b0; // R4
            shift_dr_flag_out <= 1'b0;
            capture_dr_flag_out <= 1'b0;
            update_dr_flag_out <= 1'b0;
            user_serial_in_out <= 1'b0;
            user_shift_clock_out <= 1'b0;
        end
        else
        begin
            tap_reset_n_out <= state != TLR; // R3 R4
            shift_dr_flag_out <= state == SH_DR; // R7 R19 R14
            capture_dr_flag_out <= state == CAP_DR; // R7 R19
            update_dr_flag_out <= state == UP_DR; // R7 R19 R14
            user_serial_in_out <= s2.tdi; // R5
            user_shift_clock_out <= s2.tck; // R5
        end
    end

    // clock conditioner configuration
    cfg_bit_fifo #(
        .W(FIFO_W),
        .DEPTH(FIFO_DEPTH)
    ) cfg_fifo (
        .clk_sys_in(clk_sys_in),
        .rst_in(rst_in),
        .in_data_in(cfg_bit_in),
        .in_valid_in(cfg_valid_in),
        .in_ready_out(cfg_ready_out),
        .out_data_out(fifo_bit),
        .out_valid_out(fifo_valid),
        .out_ready_in(!ctrl[CTRL_HOLD_BIT])
    );

    always_ff @(posedge clk_sys_in)
    begin
        if (rst_in)
        begin
            cfg_shift <= '0;
            cfg_active <= STATIC_CFG;
            clock_conditioner_out <= STATIC_CFG;
        end
        else
        begin
            if (drain)
            begin
                cfg_shift <= {fifo_bit, cfg_shift[CFG_W-1:1]}; // R18
            end
            if (wr_load)
            begin
                cfg_active <= cfg_shift; // R16 R17
            end
            clock_conditioner_out <= ctrl[CTRL_DYN_BIT] ? cfg_active : STATIC_CFG; // R15
        end
    end

    // register port
    always_comb
    begin
        next_rdata = RDATA_NONE;
        case (reg_addr_in)
            REG_CTRL: next_rdata = {30'h0000_0000, ctrl};
            REG_STATUS: next_rdata = status_word;
            REG_IR: next_rdata = {24'h00_0000, user_instruction_bus_out};
            default: next_rdata = RDATA_NONE;
        endcase
    end

    always_ff @(posedge clk_sys_in)
    begin
        if (rst_in)
        begin
            ctrl <= CTRL_RESET;
            reg_rdata_out <= RDATA_NONE;
        end
        else
        begin
            ctrl <= wr_ctrl ? reg_wdata_in[1:0] : ctrl;
            reg_rdata_out <= reg_rd_in ? next_rdata : RDATA_NONE;
        end
    end

    tlr_reset_a: assert property (@(posedge clk_sys_in) disable iff (rst_in) // R3
        state == TLR |=> !tap_reset_n_out)
        else $error("tap reset not low in test-logic-reset");

    shift_flag_a: assert property (@(posedge clk_sys_in) disable iff (rst_in) // R7
        ##1 shift_dr_flag_out == $past(state == SH_DR))
        else $error("shift flag does not follow shift_dr");

    capture_flag_a: assert property (@(posedge clk_sys_in) disable iff (rst_in) // R7
        (state == CAP_DR) [*1] ##1 (state != CAP_DR) |-> capture_dr_flag_out)
        else $error("capture flag missing for capture_dr");

    update_flag_a: assert property (@(posedge clk_sys_in) disable iff (rst_in) // R7
        state != UP_DR |=> !update_dr_flag_out)
        else $error("update flag high outside update_dr");

    ir_update_a: assert property (@(posedge clk_sys_in) disable iff (rst_in) // R1
        $rose(state == UP_IR) |-> user_instruction_bus_out == ir_shift)
        else $error("instruction bus not loaded on update_ir");

    ir_hold_a: assert property (@(posedge clk_sys_in) disable iff (rst_in) // R1
        (state != TLR && !$rose(state == UP_IR)) |-> $stable(user_instruction_bus_out))
        else $error("instruction bus changed outside update_ir");

    trst_tlr_a: assert property (@(posedge clk_sys_in) disable iff (rst_in) // R9
        force_tlr |=> state == TLR)
        else $error("trst did not force test-logic-reset");

    five_tms_a: assert property (@(posedge clk_sys_in) disable iff (rst_in) // R10
        tms_cnt == TMS_RESET_COUNT |-> state == TLR)
        else $error("five tms-high cycles missed test-logic-reset");

    tck_edge_a: assert property (@(posedge clk_sys_in) disable iff (rst_in) // R8
        (!tck_rise && !force_tlr) |=> $stable(state))
        else $error("tap state moved without rising tck");

    user_tdo_a: assert property (@(posedge clk_sys_in) disable iff (rst_in) // R6
        (tck_fall && state == SH_DR && user_range) |=> tdo_out == $past(s2.user_out))
        else $error("user serial output not routed to tdo");

    serial_pass_a: assert property (@(posedge clk_sys_in) disable iff (rst_in) // R5
        ##1 (user_serial_in_out == $past(s2.tdi)) && (user_shift_clock_out == $past(s2.tck)))
        else $error("serial input or shift clock not passed through");

    cfg_load_a: assert property (@(posedge clk_sys_in) disable iff (rst_in) // R17
        (wr_load && ctrl[CTRL_DYN_BIT] && !wr_ctrl) ##1 ctrl[CTRL_DYN_BIT]
        |=> clock_conditioner_out == $past(cfg_shift, 2))
        else $error("loaded configuration not applied");
endmodule

// *** verif/jtag_host_model.sv ***
`timescale 1ns/1ps

module jtag_host_model (
    output logic tck_out,
    output logic tms_out,
    output logic tdi_out,
    output logic trst_n_out,
    input wire logic tdo_in
);
    initial
    begin
        tck_out = 1'b0;
        tms_out = 1'b1;
        tdi_out = 1'b0;
        trst_n_out = 1'b1;
    end

    // one 400 ns tck period; tck rests low between frames
    task automatic step(input logic tms, input logic tdi, output logic tdo);
        tms_out = tms;
        tdi_out = tdi;
        #200 tck_out = 1'b1;
        #100 tdo = tdo_in;
        #100 tck_out = 1'b0;
        tdi_out = ~tdi;
    endtask

    // full ir or dr path from run-test-idle back to run-test-idle
    task automatic scan(input logic ir, input logic [7:0] d, output logic [7:0] q);
        logic t;
        #17 step(1'b1, 1'b0, t);
        if (ir)
        begin
            step(1'b1, 1'b0, t);
        end
        step(1'b0, 1'b0, t);
        step(1'b0, 1'b0, t);
        for (int i = 0; i < 8; i++)
        begin
            step(i == 7, d[i], q[i]);
        end
        step(1'b1, 1'b0, t);
        step(1'b0, 1'b0, t);
        #250;
    endtask

    task automatic go_idle();
        logic t;
        #17 step(1'b0, 1'b0, t);
        #250;
    endtask

    // from idle into shift_dr, then five tms-high cycles
    task automatic tms_reset();
        logic t;
        #17 step(1'b1, 1'b0, t);
        step(1'b0, 1'b0, t);
        step(1'b0, 1'b0, t);
        repeat (5) step(1'b1, 1'b0, t);
        #250;
    endtask

    task automatic pulse_trst();
        trst_n_out = 1'b0;
        #300 trst_n_out = 1'b1;
        #250;
    endtask
endmodule

// *** verif/user_jtag_tap_bridge_tb.sv ***
`timescale 1ns/1ps

module user_jtag_tap_bridge_tb
    import tap_bridge_pkg::*;
;
    logic clk_sys_in = 1'b0;
    logic rst_in = 1'b1;
    logic tck, tms, tdi, trst_n, tdo, tdo_oe, rst_n, usi, usc, sh_f, cap_f, upd_f, rdy;
    logic user_serial_out_in = 1'b0;
    logic cfg_bit_in = 1'b0;
    logic cfg_valid_in = 1'b0;
    logic [3:0] reg_addr_in = 4'h0;
    logic [31:0] reg_wdata_in = 32'h0000_0000;
    logic reg_wr_in = 1'b0;
    logic reg_rd_in = 1'b0;
    logic [31:0] reg_rdata_out, rdata;
    logic [7:0] ir_bus;
    cc_cfg_t cc_out;
    logic [80:0] exp_cfg = '0;
    logic [31:0] seed = 32'h3958_7c15;
    int fails = 0;
    int cmp_count = 0;
    int nbits = 0;
    int cap_cnt, sh_cnt, upd_cnt, oe_cnt;

    always #25 clk_sys_in = ~clk_sys_in;

    jtag_host_model host (.tck_out(tck), .tms_out(tms), .tdi_out(tdi), .trst_n_out(trst_n),
        .tdo_in(tdo));

    user_tap_bridge_tile dut (.clk_sys_in(clk_sys_in), .rst_in(rst_in), .tck_in(tck),
        .tms_in(tms), .tdi_in(tdi), .trst_n_in(trst_n), .tdo_out(tdo), .tdo_oe_out(tdo_oe),
        .user_instruction_bus_out(ir_bus), .tap_reset_n_out(rst_n), .user_serial_in_out(usi),
        .user_shift_clock_out(usc), .shift_dr_flag_out(sh_f), .capture_dr_flag_out(cap_f),
        .update_dr_flag_out(upd_f), .user_serial_out_in(user_serial_out_in),
        .cfg_bit_in(cfg_bit_in), .cfg_valid_in(cfg_valid_in), .cfg_ready_out(rdy),
        .clock_conditioner_out(cc_out), .reg_addr_in(reg_addr_in), .reg_wdata_in(reg_wdata_in),
        .reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in), .reg_rdata_out(reg_rdata_out));

    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction

    function automatic logic is_user(input logic [7:0] c);
        return c >= 8'h10 && c <= 8'h7F;
    endfunction

    task automatic check(input string what, input logic [80:0] exp, input logic [80:0] got);
        cmp_count++;
        if (got !== exp)
        begin
            fails++;
            $display("Error %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic close_out();
        $display("compares %0d mismatches %0d", cmp_count, fails);
        if (fails == 0 && cmp_count > 0)
        begin
            $display("All tests passed");
        end
        else
        begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    task automatic reg_wr(input logic [3:0] a, input logic [31:0] d);
        @(posedge clk_sys_in);
        reg_addr_in <= a;
        reg_wdata_in <= d;
        reg_wr_in <= 1'b1;
        @(posedge clk_sys_in);
        reg_wr_in <= 1'b0;
    endtask

    task automatic reg_rd(input logic [3:0] a);
        @(posedge clk_sys_in);
        reg_addr_in <= a;
        reg_rd_in <= 1'b1;
        @(posedge clk_sys_in);
        reg_rd_in <= 1'b0;
        #1 rdata = reg_rdata_out;
    endtask

    // offer config bits, holding each one until it is taken
    task automatic feed(input int cycles);
        logic taken;
        cfg_valid_in <= nbits < 81;
        repeat (cycles)
        begin
            @(negedge clk_sys_in);
            taken = rdy === 1'b1 && cfg_valid_in;
            @(posedge clk_sys_in);
            if (taken)
            begin
                exp_cfg = {cfg_bit_in, exp_cfg[80:1]};
                nbits++;
                seed = lfsr(seed);
                cfg_bit_in <= seed[0];
                cfg_valid_in <= nbits < 81;
            end
        end
        cfg_valid_in <= 1'b0;
    endtask

    always @(posedge tck)
    begin
        #190;
        check("shift clock copy", 1'b1, usc);
        check("serial in copy", tdi, usi);
    end

    always @(posedge clk_sys_in)
    begin
        cap_cnt = cap_cnt + (cap_f === 1'b1);
        sh_cnt = sh_cnt + (sh_f === 1'b1);
        upd_cnt = upd_cnt + (upd_f === 1'b1);
        oe_cnt = oe_cnt + (tdo_oe === 1'b1);
    end

    initial
    begin
        logic [7:0] codes [5];
        logic [7:0] q, d;
        repeat (5) @(posedge clk_sys_in);
        rst_in <= 1'b0;
        repeat (4) @(posedge clk_sys_in);
        check("reset tap_reset_n", 1'b0, rst_n);
        check("reset instruction", 8'hFF, ir_bus);
        reg_rd(REG_CTRL);
        check("ctrl reset", 32'h0000_0000, rdata);
        reg_rd(4'h2);
        check("unmapped read", 32'h0000_0000, rdata);
        host.go_idle();
        check("idle tap_reset_n", 1'b1, rst_n);
        seed = lfsr(seed);
        codes = '{8'h10, 8'h7F, 8'h10 + {1'b0, seed[6:0]} % 8'd112, 8'h0F, 8'h80};
        foreach (codes[i])
        begin
            cap_cnt = 0;
            sh_cnt = 0;
            upd_cnt = 0;
            oe_cnt = 0;
            host.scan(1'b1, codes[i], q);
            check("ir capture out", 8'h01, q);
            check("instruction bus", codes[i], ir_bus);
            check("ir path flags", 0, cap_cnt + sh_cnt + upd_cnt);
            reg_rd(REG_IR);
            check("ir register", codes[i], rdata);
            seed = lfsr(seed);
            d = seed[15:8];
            @(posedge clk_sys_in);
            user_serial_out_in <= seed[0];
            host.scan(1'b0, d, q);
            check("dr tdo", is_user(codes[i]) ? {8{seed[0]}} : {d[6:0], 1'b0}, q);
            check("capture cycles", 8, cap_cnt);
            check("shift cycles", 64, sh_cnt);
            check("update cycles", 8, upd_cnt);
            check("tdo enable cycles", 128, oe_cnt);
            $display("test instruction %h done", codes[i]);
        end
        reg_wr(REG_IR, 32'h0000_0033);
        reg_rd(REG_IR);
        check("ir read only", 8'h80, rdata);
        host.tms_reset();
        check("tms reset tap_reset_n", 1'b0, rst_n);
        check("tms reset instruction", 8'hFF, ir_bus);
        reg_rd(REG_STATUS);
        check("tms reset state", 5'h00, rdata[4:0]);
        host.go_idle();
        host.scan(1'b1, 8'h55, q);
        host.pulse_trst();
        check("trst tap_reset_n", 1'b0, rst_n);
        check("trst instruction", 8'hFF, ir_bus);
        $display("test tap reset done");
        reg_wr(REG_CTRL, 32'h0000_0002);
        feed(40);
        check("fifo fill count", 32, nbits);
        reg_rd(REG_STATUS);
        check("fifo nonempty", 1'b1, rdata[5]);
        reg_wr(REG_CTRL, 32'h0000_0000);
        feed(120);
        check("config bit count", 81, nbits);
        if (nbits != 81)
        begin
            close_out();
        end
        repeat (40) @(posedge clk_sys_in);
        reg_rd(REG_STATUS);
        check("fifo drained", 1'b0, rdata[5]);
        reg_wr(REG_CTRL, 32'h0000_0001);
        repeat (2) @(posedge clk_sys_in);
        check("dynamic before load", STATIC_CFG, cc_out);
        reg_wr(REG_LOAD, 32'h0000_0000);
        repeat (2) @(posedge clk_sys_in);
        check("dynamic config", exp_cfg, cc_out);
        reg_wr(REG_CTRL, 32'h0000_0000);
        repeat (2) @(posedge clk_sys_in);
        check("static config", STATIC_CFG, cc_out);
        $display("test config done");
        close_out();
    end
endmodule
